/* inc/stp_pkg.sv */
// Constants of the shared timer prescaler
package stp_pkg;
    // Register map: I/O offset and data-space alias
    localparam logic [6:0] STP_CTRL_IO_OFS = 7'h20;
    localparam logic [6:0] STP_DATA_SPACE_ADD = 7'h20;
    localparam logic [6:0] STP_IO_SPACE_TOP = 7'h3F;
    localparam logic [7:0] STP_CTRL_RESET = 8'h00;
    // Field positions
    localparam int STP_BIT_SYNC_HOLD = 7;
    localparam int STP_BIT_OTHER_RST = 1;
    localparam int STP_BIT_SHARED_RST = 0;
    // Tick source select codes
    localparam logic [2:0] STP_SEL_STOP = 3'h0;
    localparam logic [2:0] STP_SEL_CLK = 3'h1;
    localparam logic [2:0] STP_SEL_DIV8 = 3'h2;
    localparam logic [2:0] STP_SEL_DIV64 = 3'h3;
    localparam logic [2:0] STP_SEL_DIV256 = 3'h4;
    localparam logic [2:0] STP_SEL_DIV1024 = 3'h5;
    localparam logic [2:0] STP_SEL_FALL = 3'h6;
    localparam logic [2:0] STP_SEL_RISE = 3'h7;
    // Divider taps
    localparam int STP_DIV_W = 10;
    localparam logic [9:0] STP_MASK8 = 10'h007;
    localparam logic [9:0] STP_MASK64 = 10'h03F;
    localparam logic [9:0] STP_MASK256 = 10'h0FF;
    localparam logic [9:0] STP_MASK1024 = 10'h3FF;
    localparam int STP_TIMERS = 3;
endpackage

/* src/stp_prescaler.sv */
// Shared three-timer prescaler with pin sync, edge detect and control register
// How it works
// RULE1 - Select 1 ticks every system clock
// RULE2 - Taps divide clock by 8/64/256/1024
// RULE3 - Free-running divider shared by three timers
// RULE4 - First divided tick within 1..N+1 cycles
// RULE5 - Divider reset restarts all timers' taps
// RULE6 - Pin: high-transparent latch, then flops
// RULE7 - One tick per rising/falling edge
// RULE8 - Pin edge to tick 2.5-3.5 cycles
// RULE9 - Software switches external source only when stable
// RULE10 - External clock slower than half system clock
// RULE11 - Pin ticks bypass the divider
// RULE12 - Hold bit keeps both reset bits
// RULE13 - Clearing hold clears both reset bits
// RULE14 - Shared reset bit self-clears without hold
// RULE15 - Control register at I/O 0x20
// RULE16 - Select 0 gives no ticks
// RULE17 - Selects 2..5 pick 8/64/256/1024
// RULE18 - Reset holds divider at zero
`timescale 1ns/1ps
module stp_prescaler (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // I/O register port (I/O-space address)
    input wire logic [6:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // Per-timer tick source select
    input wire logic [2:0] tick_source_select [stp_pkg::STP_TIMERS],
    // External count pins
    input wire logic [stp_pkg::STP_TIMERS-1:0] ext_count_pin,
    // Timer ticks and halt indication
    output logic [stp_pkg::STP_TIMERS-1:0] timer_tick,
    output logic shared_divider_reset,
    output logic other_divider_reset,
    output logic sync_hold_enable
);
    import stp_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [STP_DIV_W-1:0] div;
        logic [STP_TIMERS-1:0] sync1;
        logic [STP_TIMERS-1:0] sync2;
        logic [STP_TIMERS-1:0] prev;
        logic [STP_TIMERS-1:0] tick;
        logic [7:0] rdata;
    } stp_state_type;

    stp_state_type state_reg;
    stp_state_type state_next;
    logic [STP_TIMERS-1:0] pin_latch;
    logic [STP_DIV_W-1:0] div_inc;
    logic ctrl_hit;

    // ==========================================
    // Pin latch, transparent while clk is high
    always_latch begin
        if (clk) begin
            pin_latch <= ext_count_pin; // RULE6
        end
    end

    assign ctrl_hit = (io_addr == STP_CTRL_IO_OFS); // RULE15
    assign div_inc = state_reg.div + 10'h001;

    // ==========================================
    // Next state
    always_comb begin
        logic [STP_TIMERS-1:0] rise;
        logic [STP_TIMERS-1:0] fall;
        logic [9:0] mask;
        rise = '0;
        fall = '0;
        mask = '0;
        state_next = state_reg;
        // Register write and self-clearing
        if (io_wr && ctrl_hit) begin
            state_next.ctrl = {io_wdata[7], 5'h00, io_wdata[1:0]};
        end
        if (!state_next.ctrl[STP_BIT_SYNC_HOLD]) begin
            // Old hold set and now cleared: both bits drop together
            if (state_reg.ctrl[STP_BIT_SYNC_HOLD]) begin
                state_next.ctrl[STP_BIT_OTHER_RST] = 1'b0; // RULE13
            end
            if (state_reg.ctrl[STP_BIT_SHARED_RST] && !(io_wr && ctrl_hit)) begin
                state_next.ctrl[STP_BIT_SHARED_RST] = 1'b0; // RULE14
            end
            if (state_reg.ctrl[STP_BIT_SYNC_HOLD]) begin
                state_next.ctrl[STP_BIT_SHARED_RST] = 1'b0; // RULE13
            end
        end // RULE12 keeps the bits when hold stays set
        // Free-running divider, held at zero in reset
        if (state_reg.ctrl[STP_BIT_SHARED_RST]) begin
            state_next.div = '0; // RULE5 RULE18
        end else begin
            state_next.div = div_inc; // RULE3
        end
        // Pin synchroniser and edge detector
        state_next.sync1 = pin_latch; // RULE6
        state_next.sync2 = state_reg.sync1;
        state_next.prev = state_reg.sync2;
        rise = state_reg.sync2 & ~state_reg.prev;
        fall = ~state_reg.sync2 & state_reg.prev;
        for (int i = 0; i < STP_TIMERS; i++) begin
            state_next.tick[i] = 1'b0;
            unique case (tick_source_select[i])
                STP_SEL_STOP: state_next.tick[i] = 1'b0; // RULE16
                STP_SEL_CLK: state_next.tick[i] = 1'b1; // RULE1
                STP_SEL_DIV8: mask = STP_MASK8; // RULE17
                STP_SEL_DIV64: mask = STP_MASK64;
                STP_SEL_DIV256: mask = STP_MASK256;
                STP_SEL_DIV1024: mask = STP_MASK1024;
                STP_SEL_FALL: state_next.tick[i] = fall[i]; // RULE7 RULE11
                STP_SEL_RISE: state_next.tick[i] = rise[i]; // RULE7 RULE11
            endcase
            if (tick_source_select[i] inside {[STP_SEL_DIV8:STP_SEL_DIV1024]}) begin
                state_next.tick[i] = !state_reg.ctrl[STP_BIT_SHARED_RST]
                    && ((state_reg.div & mask) == mask); // RULE2 RULE4
            end
        end
        // Read data
        state_next.rdata = (io_rd && ctrl_hit) ? state_reg.ctrl : 8'h00;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign timer_tick = state_reg.tick;
    assign io_rdata = state_reg.rdata;
    assign shared_divider_reset = state_reg.ctrl[STP_BIT_SHARED_RST];
    assign other_divider_reset = state_reg.ctrl[STP_BIT_OTHER_RST];
    assign sync_hold_enable = state_reg.ctrl[STP_BIT_SYNC_HOLD];

    // ==========================================
    // Assertions
    sequence hold_drop_s;
        state_reg.ctrl[STP_BIT_SYNC_HOLD] && !state_next.ctrl[STP_BIT_SYNC_HOLD];
    endsequence

    hold_release_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE13
        hold_drop_s |=> !shared_divider_reset && !other_divider_reset)
        else $error("reset bits not cleared on hold release");
    hold_keep_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE12
        sync_hold_enable && shared_divider_reset && !io_wr |=> shared_divider_reset)
        else $error("reset bit lost while hold set");
    self_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE14
        shared_divider_reset && !sync_hold_enable && !io_wr |=> !shared_divider_reset)
        else $error("reset bit did not self-clear");
    div_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE18
        shared_divider_reset |=> state_reg.div == '0)
        else $error("divider not held at zero");
    div_run_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE3
        !shared_divider_reset |=> state_reg.div == $past(state_reg.div) + 10'h001)
        else $error("divider not free running");
    fast_tick_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
        tick_source_select[0] == STP_SEL_CLK |=> timer_tick[0])
        else $error("select 1 missed a tick");
    stop_tick_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE16
        tick_source_select[0] == STP_SEL_STOP |=> !timer_tick[0])
        else $error("tick while stopped");
    div8_gap_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
        tick_source_select[0] == STP_SEL_DIV8 && timer_tick[0] |=> !timer_tick[0])
        else $error("divide by 8 ticked twice");
    edge_lat_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
        tick_source_select[0] == STP_SEL_RISE && $rose(state_reg.sync1[0])
        && $stable(tick_source_select[0]) |=> ##1 timer_tick[0])
        else $error("rising edge tick latency wrong");
    fall_lat_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
        tick_source_select[1] == STP_SEL_FALL && $fell(state_reg.sync1[1])
        && $stable(tick_source_select[1]) |=> ##1 timer_tick[1])
        else $error("falling edge tick latency wrong");
    other_keep_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE12
        sync_hold_enable && other_divider_reset && !io_wr |=> other_divider_reset)
        else $error("other reset bit lost while hold set");
    tap_gate_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
        shared_divider_reset && tick_source_select[1] inside {[STP_SEL_DIV8:STP_SEL_DIV1024]}
        |=> !timer_tick[1])
        else $error("divided tick during divider reset");
    pin_only_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
        tick_source_select[2] == STP_SEL_RISE && state_reg.sync2[2] == state_reg.prev[2]
        |=> !timer_tick[2])
        else $error("pin source ticked without an edge");
    ctrl_read_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE15
        io_rd && io_addr == STP_CTRL_IO_OFS
        |=> io_rdata == $past({sync_hold_enable, 5'h00, other_divider_reset,
            shared_divider_reset}))
        else $error("control read returned wrong data");

    // ==========================================
    // First divided tick after the divider restarts
    sequence tap_start_s;
        $fell(shared_divider_reset) && tick_source_select[0] == STP_SEL_DIV8;
    endsequence

    sequence tick_due_s;
        ##[1:9] timer_tick[0];
    endsequence

    first_tap_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
        tap_start_s |-> tick_due_s)
        else $error("first divide by 8 tick late");
    reg_read_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE15
        io_rd && io_addr != STP_CTRL_IO_OFS |=> io_rdata == 8'h00)
        else $error("unmapped read returned data");
endmodule // stp_prescaler

/* tb/stp_pin_model.sv */
// External count source driving the three count pins
`timescale 1ns/1ps
module stp_pin_model (
    // Clock
    input wire logic clk,
    // Control
    input wire logic run,
    input wire logic [3:0] half,
    // Pins
    output logic [2:0] pin
);
    logic [3:0] cnt_reg = 4'h0;
    initial pin = 3'h0;
    // Toggle every half cycles, stay put outside a burst
    // Run is driven on the falling edge, so it is sampled here on the rising one
    always @(posedge clk) begin
        if (run && cnt_reg + 4'h1 >= half) begin
            pin <= ~pin;
            cnt_reg <= 4'h0;
        end else if (run) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule // stp_pin_model

/* tb/tb_stp_prescaler.sv */
// Self-checking bench of the shared timer prescaler
`timescale 1ns/1ps
module tb_stp_prescaler;
    import stp_pkg::*;
    logic clk, rst_b, io_wr, io_rd, run, hold, srst, orst;
    logic [6:0] io_addr;
    logic [7:0] io_wdata, io_rdata;
    logic [2:0] sel [STP_TIMERS];
    logic [2:0] pin, tick;
    logic [15:0] cnt [3];
    int errors = 0, checked = 0, cycles = 0;
    stp_prescaler DUT (.clk(clk), .rst_b(rst_b), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .tick_source_select(sel),
        .ext_count_pin(pin), .timer_tick(tick), .shared_divider_reset(srst),
        .other_divider_reset(orst), .sync_hold_enable(hold));
    stp_pin_model partner (.clk(clk), .run(run), .half(4'h3), .pin(pin));
    // ==========
    // Clock, tick counters and timeout
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles = cycles + 1;
        for (int i = 0; i < 3; i++) cnt[i] <= cnt[i] + 16'(tick[i]);
        if (cycles == 5000) begin
            errors++;
            conclude();
        end
    end
    // ==========
    // Tasks
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] v);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge clk);
        v = io_rdata;
        io_rd = 1'b0;
    endtask
    task automatic window(input int n);
        for (int i = 0; i < 3; i++) cnt[i] = 16'h0;
        repeat (n) @(negedge clk);
    endtask
    task automatic t_reg();
        logic [7:0] v;
        rd(STP_CTRL_IO_OFS, v);
        chk("ctrl reset", 16'(STP_CTRL_RESET), 16'(v));
        wr(STP_CTRL_IO_OFS, 8'h01);
        chk("shared reset set", 16'h1, 16'(srst));
        @(negedge clk);
        chk("shared reset clear", 16'h0, 16'(srst));
        wr(STP_IO_SPACE_TOP, 8'h83);
        rd(STP_IO_SPACE_TOP, v);
        chk("unmapped read", 16'h0, 16'(v));
        chk("unmapped write", 16'h0, {13'h0, hold, orst, srst});
    endtask
    task automatic t_sync(input logic [2:0] s0, s1, s2, input logic [15:0] e0, e1, e2);
        logic [7:0] v;
        wr(STP_CTRL_IO_OFS, 8'h83);
        sel[0] = s0;
        sel[1] = s1;
        sel[2] = s2;
        window(4);
        window(40);
        chk("held tick", 16'h0, cnt[0]);
        rd(STP_CTRL_IO_OFS, v);
        chk("held ctrl", 16'h83, 16'(v));
        wr(STP_CTRL_IO_OFS, 8'h00);
        chk("released bits", 16'h0, {13'h0, hold, orst, srst});
        window(1028);
        chk("timer0 ticks", e0, cnt[0]);
        chk("timer1 ticks", e1, cnt[1]);
        chk("timer2 ticks", e2, cnt[2]);
    endtask
    task automatic t_pin();
        sel[0] = STP_SEL_RISE;
        sel[1] = STP_SEL_FALL;
        sel[2] = STP_SEL_RISE;
        window(2);
        run = 1'b1;
        window(24);
        run = 1'b0;
        repeat (6) @(negedge clk);
        chk("rise ticks", 16'h4, cnt[0]);
        chk("fall ticks", 16'h4, cnt[1]);
        chk("rise ticks timer2", 16'h4, cnt[2]);
    endtask
    task automatic conclude();
        if (errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ==========
    // Main sequence
    initial begin
        rst_b = 1'b0;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_addr = 7'h0;
        io_wdata = 8'h0;
        run = 1'b0;
        sel = '{default: STP_SEL_STOP};
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        t_reg();
        t_sync(STP_SEL_DIV8, STP_SEL_DIV64, STP_SEL_DIV256, 16'h80, 16'h10, 16'h4);
        t_sync(STP_SEL_DIV1024, STP_SEL_STOP, STP_SEL_CLK, 16'h1, 16'h0, 16'h404);
        t_pin();
        conclude();
    end
endmodule // tb_stp_prescaler
